// *** core/arw_framer.sv ***
// word framer: host byte port, transmit and receive word paths, level flag
// How it works
// - flag selector is control bits 1:0, reset to zero, picks the flag condition.
// - selector 00 raises the level flag while the receive buffer is empty.
// - selector 01 raises the level flag when the buffer holds 32 words.
// - selector 10 raises the level flag at sixteen or more words.
// - selector 11 raises the level flag when at least one word is held.
// - a word is 32 bits; first eight on the line are the label.
// - the 23 bits after the label are the data field.
// - the last, 32nd bit sent is odd parity over the word.
// - transmit writes and receive reads carry exactly four data bytes.
// - label msb is word bit 1, data msb bit 31: opposite significance.
// - transmit reverse bit set reverses the label just before sending.
// - receive reverse bit set reverses the label as the word arrives.
// - receive reverse never alters how the priority match is compared.
// - priority register reads leave out the label byte.
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// fifo
module arw_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    // fill level
    output logic [CNT_W-1:0] o_count
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [CNT_W-1:0] count, next_count;
    logic push, pop;

    assign o_in_ready = (count != CNT_W'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];
    assign o_count = count;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        next_wr_ptr = push ? PTR_W'((wr_ptr == PTR_W'(DEPTH - 1)) ? 0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PTR_W'((rd_ptr == PTR_W'(DEPTH - 1)) ? 0 : rd_ptr + 1'b1) : rd_ptr;
        next_count = count + CNT_W'(push) - CNT_W'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset; only entries below count are ever read
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule : arw_fifo

// =========================================================================
// top
module arw_framer
    import arw_pkg::*;
#(
    parameter int TX_FIFO_DEPTH = arw_pkg::TX_DEPTH,
    parameter int RX_FIFO_DEPTH = arw_pkg::RX_DEPTH
) (
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // host byte port (from serial port logic on the core clock)
    input wire logic i_host_byte_valid,
    input wire logic i_host_op_start,
    input wire logic [7:0] i_host_byte,
    output logic o_host_ready,
    output logic [7:0] o_host_rd_byte,
    // level flag pin
    output logic o_rx1_level_flag,
    // link side, on the link clock
    input wire logic i_link_clk,
    input wire logic i_link_resetn,
    input wire logic i_link_rx_valid,
    input wire logic i_link_rx_start,
    input wire logic i_link_rx_bit,
    output logic o_link_tx_bit,
    output logic o_link_tx_active
);
    import arw_pkg::*;

    localparam int RXC_W = $clog2(RX_FIFO_DEPTH + 1);

    function automatic logic [LABEL_W-1:0] rev_label(input logic [LABEL_W-1:0] l);
        logic [LABEL_W-1:0] r;
        r = '0;
        for (int k = 0; k < LABEL_W; k++) begin
            r[k] = l[LABEL_W-1-k];
        end
        return r;
    endfunction : rev_label

    // =====================================================================
    // host transaction state
    arw_host_state_t state, next_state;
    logic [1:0] byte_cnt, next_byte_cnt;
    logic [WORD_W-1:0] wr_word, next_wr_word;
    logic push_pend, next_push_pend;
    logic [7:0] ctrl, next_ctrl;
    logic [7:0] match, next_match;
    logic [WORD_W-1:0] rd_shift, next_rd_shift;
    logic [2:0] rd_left, next_rd_left;
    logic rx_pop;
    logic [1:0] flag_sel;
    logic tx_rev, rx_rev;
    logic take;

    logic tx_in_ready, tx_out_valid, tx_pop;
    logic [WORD_W-1:0] tx_out_data;
    logic rx_push, rx_out_valid;
    logic [WORD_W-1:0] rx_in_data, rx_out_data, prio_word;
    logic [RXC_W-1:0] rx_count;

    assign flag_sel = ctrl[CTRL_SEL_LSB +: 2];
    assign tx_rev = ctrl[CTRL_TXREV_BIT];
    assign rx_rev = ctrl[CTRL_RXREV_BIT];
    assign o_host_ready = !push_pend;
    assign take = i_host_byte_valid && !push_pend;
    assign o_host_rd_byte = rd_shift[WORD_W-1 -: 8];

    always_comb begin
        next_state = state;
        next_byte_cnt = byte_cnt;
        next_wr_word = wr_word;
        next_push_pend = push_pend && !tx_in_ready;
        next_ctrl = ctrl;
        next_match = match;
        next_rd_shift = rd_shift;
        next_rd_left = rd_left;
        rx_pop = 1'b0;
        if (take && i_host_op_start) begin
            next_byte_cnt = 2'h0;
            next_rd_shift = '0;
            case (i_host_byte)
                OP_WR_TX: next_state = ARW_WR_TX;
                OP_WR_CTRL: next_state = ARW_WR_CTRL;
                OP_WR_MATCH: next_state = ARW_WR_MATCH;
                OP_RD_RX1: begin
                    next_state = ARW_RD_WORD;
                    next_rd_left = 3'(BYTES_WORD);
                    rx_pop = rx_out_valid;
                    next_rd_shift = rx_out_valid ? rx_out_data : '0;
                end
                OP_RD_PRIO: begin
                    next_state = ARW_RD_WORD;
                    next_rd_left = 3'(BYTES_PRIO);
                    next_rd_shift = {prio_word[WORD_W-1:DATA_LSB], 8'h00};
                end
                default: next_state = ARW_IDLE;
            endcase
        end else if (take) begin
            case (state)
                ARW_WR_TX: begin
                    next_wr_word = {wr_word[WORD_W-9:0], i_host_byte};
                    next_byte_cnt = byte_cnt + 2'h1;
                    if (byte_cnt == 2'(BYTES_WORD - 1)) begin
                        next_push_pend = 1'b1;
                        next_state = ARW_IDLE;
                    end
                end
                ARW_WR_CTRL: begin
                    next_ctrl = i_host_byte;
                    next_state = ARW_IDLE;
                end
                ARW_WR_MATCH: begin
                    next_match = i_host_byte;
                    next_state = ARW_IDLE;
                end
                ARW_RD_WORD: begin
                    next_rd_shift = {rd_shift[WORD_W-9:0], 8'h00};
                    next_rd_left = rd_left - 3'h1;
                    if (rd_left == 3'h1) begin
                        next_state = ARW_IDLE;
                    end
                end
                default: next_state = ARW_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            state <= ARW_IDLE;
            byte_cnt <= 2'h0;
            wr_word <= '0;
            push_pend <= 1'b0;
            ctrl <= CTRL_RST;
            match <= MATCH_RST;
            rd_shift <= '0;
            rd_left <= 3'h0;
        end else begin
            state <= next_state;
            byte_cnt <= next_byte_cnt;
            wr_word <= next_wr_word;
            push_pend <= next_push_pend;
            ctrl <= next_ctrl;
            match <= next_match;
            rd_shift <= next_rd_shift;
            rd_left <= next_rd_left;
        end
    end

    // =====================================================================
    // buffers
    arw_fifo #(.WIDTH(WORD_W), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
        .i_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_in_valid(push_pend),
        .o_in_ready(tx_in_ready),
        .i_in_data(wr_word),
        .o_out_valid(tx_out_valid),
        .i_out_ready(tx_pop),
        .o_out_data(tx_out_data),
        .o_count()
    );

    arw_fifo #(.WIDTH(WORD_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
        .i_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_in_valid(rx_push),
        .o_in_ready(),
        .i_in_data(rx_in_data),
        .o_out_valid(rx_out_valid),
        .i_out_ready(rx_pop),
        .o_out_data(rx_out_data),
        .o_count(rx_count)
    );

    // =====================================================================
    // level flag
    logic next_flag;

    always_comb begin
        case (flag_sel)
            FLAG_EMPTY: next_flag = (rx_count == '0);
            FLAG_FULL: next_flag = (rx_count == RXC_W'(RX_DEPTH));
            FLAG_HALF: next_flag = (rx_count >= RXC_W'(RX_HALF));
            default: next_flag = (rx_count != '0);
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_rx1_level_flag <= 1'b0;
        end else begin
            o_rx1_level_flag <= next_flag;
        end
    end

    // =====================================================================
    // transmit launch: toggle request, the link's ack toggle comes back
    logic [WORD_W-1:0] tx_hold, next_tx_hold, tx_prep;
    logic tx_req, next_tx_req, tx_ack_l, tx_ack_s1, tx_ack_s2;

    always_comb begin
        tx_prep = tx_out_data;
        if (tx_rev) begin
            tx_prep[LABEL_W-1:0] = rev_label(tx_out_data[LABEL_W-1:0]);
        end
        tx_prep[PARITY_BIT] = ~^tx_prep[PARITY_BIT-1:0];
        tx_pop = tx_out_valid && (tx_req == tx_ack_s2);
        next_tx_hold = tx_pop ? tx_prep : tx_hold;
        next_tx_req = tx_pop ? !tx_req : tx_req;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            tx_hold <= '0;
            tx_req <= 1'b0;
            tx_ack_s1 <= 1'b0;
            tx_ack_s2 <= 1'b0;
        end else begin
            tx_hold <= next_tx_hold;
            tx_req <= next_tx_req;
            tx_ack_s1 <= tx_ack_l;
            tx_ack_s2 <= tx_ack_s1;
        end
    end

    // =====================================================================
    // link domain: serialiser and deserialiser, bit 0 of the word first
    logic tx_req_s1, tx_req_s2, next_tx_ack_l;
    logic [WORD_W-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh, rx_word_l, next_rx_word_l;
    logic [BIT_CNT_W-1:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
    logic next_tx_active, rx_tgl_l, next_rx_tgl_l;

    always_comb begin
        next_tx_ack_l = tx_ack_l;
        next_tx_sh = tx_sh;
        next_tx_cnt = tx_cnt;
        next_tx_active = o_link_tx_active;
        if (o_link_tx_active) begin
            next_tx_sh = {1'b0, tx_sh[WORD_W-1:1]};
            next_tx_cnt = tx_cnt + 1'b1;
            if (tx_cnt == BIT_CNT_W'(WORD_W - 1)) begin
                next_tx_active = 1'b0;
            end
        end else if (tx_req_s2 != tx_ack_l) begin
            next_tx_sh = tx_hold; // held stable until the ack toggle returns
            next_tx_ack_l = tx_req_s2;
            next_tx_cnt = '0;
            next_tx_active = 1'b1;
        end
        next_rx_sh = rx_sh;
        next_rx_cnt = rx_cnt;
        next_rx_word_l = rx_word_l;
        next_rx_tgl_l = rx_tgl_l;
        if (i_link_rx_valid) begin
            next_rx_sh = {i_link_rx_bit, rx_sh[WORD_W-1:1]};
            next_rx_cnt = i_link_rx_start ? BIT_CNT_W'(1) : rx_cnt + 1'b1;
            if (!i_link_rx_start && rx_cnt == BIT_CNT_W'(WORD_W - 1)) begin
                next_rx_word_l = next_rx_sh;
                next_rx_tgl_l = !rx_tgl_l;
            end
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (!i_link_resetn) begin
            tx_req_s1 <= 1'b0;
            tx_req_s2 <= 1'b0;
            tx_ack_l <= 1'b0;
            tx_sh <= '0;
            tx_cnt <= '0;
            o_link_tx_active <= 1'b0;
            rx_sh <= '0;
            rx_cnt <= '0;
            rx_word_l <= '0;
            rx_tgl_l <= 1'b0;
        end else begin
            tx_req_s1 <= tx_req;
            tx_req_s2 <= tx_req_s1;
            tx_ack_l <= next_tx_ack_l;
            tx_sh <= next_tx_sh;
            tx_cnt <= next_tx_cnt;
            o_link_tx_active <= next_tx_active;
            rx_sh <= next_rx_sh;
            rx_cnt <= next_rx_cnt;
            rx_word_l <= next_rx_word_l;
            rx_tgl_l <= next_rx_tgl_l;
        end
    end

    assign o_link_tx_bit = tx_sh[0];

    // =====================================================================
    // receive capture in the core domain; a word arriving on a full
    // buffer is dropped, since the link cannot be stalled
    logic rx_s1, rx_s2, rx_seen, rx_new;
    logic [WORD_W-1:0] next_prio_word;

    assign rx_new = (rx_s2 != rx_seen);
    assign rx_push = rx_new;

    always_comb begin
        rx_in_data = rx_word_l;
        if (rx_rev) begin
            rx_in_data[LABEL_W-1:0] = rev_label(rx_word_l[LABEL_W-1:0]);
        end
        // match compares the label as it came off the line
        next_prio_word = (rx_new && rx_word_l[LABEL_W-1:0] == match) ? rx_word_l : prio_word;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_seen <= 1'b0;
            prio_word <= '0;
        end else begin
            rx_s1 <= rx_tgl_l;
            rx_s2 <= rx_s1;
            rx_seen <= rx_s2;
            prio_word <= next_prio_word;
        end
    end

    // =====================================================================
    // checks
    sequence prio_op_s;
        take && i_host_op_start && i_host_byte == OP_RD_PRIO;
    endsequence

    sequence tx_word_s;
        take && !i_host_op_start && state == ARW_WR_TX && byte_cnt == 2'h3;
    endsequence

    select_reset_a: assert property (@(posedge i_core_clk)
        !i_resetn |=> flag_sel == FLAG_EMPTY)
        else $error("flag selector not zero after reset");
    flag_empty_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (flag_sel == FLAG_EMPTY) |=> o_rx1_level_flag == ($past(rx_count) == '0))
        else $error("empty flag wrong");
    flag_full_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (flag_sel == FLAG_FULL) |=> o_rx1_level_flag == ($past(rx_count) == RXC_W'(RX_DEPTH)))
        else $error("full flag wrong");
    flag_half_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (flag_sel == FLAG_HALF) |=> o_rx1_level_flag == ($past(rx_count) >= RXC_W'(RX_HALF)))
        else $error("half flag wrong");
    flag_any_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (flag_sel == FLAG_ANY) |=> o_rx1_level_flag == ($past(rx_count) != '0))
        else $error("not-empty flag wrong");
    tx_parity_a: assert property (@(posedge i_link_clk) disable iff (!i_link_resetn)
        $rose(o_link_tx_active) |-> ^tx_sh)
        else $error("transmitted word parity not odd");
    tx_reverse_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (tx_pop && tx_rev) |=> tx_hold[7:0] == rev_label($past(tx_out_data[7:0])))
        else $error("transmit label not reversed");
    rx_reverse_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (rx_push && rx_rev) |-> rx_in_data[0] == rx_word_l[7] && rx_in_data[7] == rx_word_l[0]
            && rx_in_data[WORD_W-1:LABEL_W] == rx_word_l[WORD_W-1:LABEL_W])
        else $error("receive label not reversed");
    word_bytes_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        tx_word_s |=> push_pend && state == ARW_IDLE && wr_word[7:0] == $past(i_host_byte))
        else $error("four-byte write did not queue a word");
    prio_read_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        prio_op_s |=> rd_shift[7:0] == 8'h00 && rd_left == 3'h3)
        else $error("priority read carries a label byte");
endmodule : arw_framer

`default_nettype wire

// *** core/arw_pkg.sv ***
// shared constants and types for the label-ordering word framer
package arw_pkg;

    // =====================================================================
    // word layout
    localparam int WORD_W = 32;
    localparam int LABEL_W = 8;
    localparam int DATA_LSB = 8;
    localparam int DATA_W = 23;
    localparam int PARITY_BIT = 31;
    localparam int BYTES_WORD = 4;
    localparam int BYTES_PRIO = 3;
    localparam int BIT_CNT_W = 5;

    // =====================================================================
    // buffer sizes
    localparam int TX_DEPTH = 16;
    localparam int RX_DEPTH = 32;
    localparam int RX_HALF = 16;

    // =====================================================================
    // host op-codes
    localparam logic [7:0] OP_WR_TX = 8'h0c;
    localparam logic [7:0] OP_WR_CTRL = 8'h10;
    localparam logic [7:0] OP_WR_MATCH = 8'h18;
    localparam logic [7:0] OP_RD_RX1 = 8'h90;
    localparam logic [7:0] OP_RD_PRIO = 8'h9c;

    // =====================================================================
    // control byte fields and reset values
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_TXREV_BIT = 2;
    localparam int CTRL_RXREV_BIT = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MATCH_RST = 8'h00;

    // =====================================================================
    // level flag selector codes
    localparam logic [1:0] FLAG_EMPTY = 2'h0;
    localparam logic [1:0] FLAG_FULL = 2'h1;
    localparam logic [1:0] FLAG_HALF = 2'h2;
    localparam logic [1:0] FLAG_ANY = 2'h3;

    typedef enum logic [2:0] {
        ARW_IDLE,
        ARW_WR_TX,
        ARW_WR_CTRL,
        ARW_WR_MATCH,
        ARW_RD_WORD
    } arw_host_state_t;

endpackage : arw_pkg

// *** sim/arw_link_model.sv ***
// far-end link transmitter model feeding the framer's receive bit stream
`timescale 1ns/1ps
`default_nettype none

module arw_link_model (
    // link clock
    input wire logic i_link_clk,
    // bit stream toward the framer
    output logic o_valid,
    output logic o_start,
    output logic o_bit
);
    initial begin
        o_valid = 1'b0;
        o_start = 1'b0;
        o_bit = 1'b0;
    end

    // =====================================================================
    // word sender, bit 0 first; slow inserts idle link cycles between bits
    task automatic send(input logic [31:0] w, input int slow);
        logic [31:0] f;
        f = {~^w[30:0], w[30:0]};
        for (int i = 0; i < 32; i++) begin
            @(posedge i_link_clk);
            o_valid <= 1'b1;
            o_start <= (i == 0);
            o_bit <= f[i];
            // idle line shows no stale value
            repeat (slow) begin
                @(posedge i_link_clk);
                o_valid <= 1'b0;
                o_start <= 1'b0;
                o_bit <= ~f[i];
            end
        end
        @(posedge i_link_clk);
        o_valid <= 1'b0;
        o_start <= 1'b0;
        o_bit <= ~f[31];
        repeat (3) @(posedge i_link_clk);
    endtask : send
endmodule : arw_link_model

`default_nettype wire

// *** sim/tb_arinc_word_label_ordering.sv ***
// self-checking bench for the label-ordering word framer
`timescale 1ns/1ps
`default_nettype none

module tb_arinc_word_label_ordering;
    import arw_pkg::*;

    logic clk, resetn, lclk, lresetn, hv, hs, rdy, flag, rv, rs, rb, tb_bit, ta;
    logic [7:0] hb, rd;
    logic [31:0] cap;
    int nbits, failures, checks_done, cyc;

    // =====================================================================
    // clocks, design and far end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #7;
        forever #16 lclk = ~lclk;
    end

    arw_framer dut_u (.i_core_clk(clk), .i_resetn(resetn), .i_host_byte_valid(hv),
        .i_host_op_start(hs), .i_host_byte(hb), .o_host_ready(rdy), .o_host_rd_byte(rd),
        .o_rx1_level_flag(flag), .i_link_clk(lclk), .i_link_resetn(lresetn),
        .i_link_rx_valid(rv), .i_link_rx_start(rs), .i_link_rx_bit(rb),
        .o_link_tx_bit(tb_bit), .o_link_tx_active(ta));

    arw_link_model model_u (.i_link_clk(lclk), .o_valid(rv), .o_start(rs), .o_bit(rb));

    // transmitted bits arrive bit 0 first, so shift in from the top
    always @(posedge lclk) begin
        if (ta === 1'b1) begin
            cap <= {tb_bit, cap[31:1]};
            nbits <= nbits + 1;
        end
    end

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    // =====================================================================
    // shared tasks
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
    endfunction : rev8

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one byte slot, held until the framer takes it
    task automatic put(input logic s, input logic [7:0] b);
        @(posedge clk);
        hv <= 1'b1;
        hs <= s;
        hb <= b;
        for (int i = 0; i < 100; i++) begin
            @(negedge clk);
            if (rdy === 1'b1) break;
            @(posedge clk);
        end
        @(posedge clk);
        hv <= 1'b0;
        hs <= 1'b0;
    endtask : put

    task automatic wr1(input logic [7:0] op, input logic [7:0] v);
        put(1'b1, op);
        put(1'b0, v);
        repeat (3) @(posedge clk);
    endtask : wr1

    task automatic rd_word(input logic [7:0] op, input int n, output logic [31:0] r);
        r = '0;
        put(1'b1, op);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            r = {r[23:0], rd};
            put(1'b0, 8'h00);
        end
    endtask : rd_word

    task automatic flag_is(input logic exp);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("level flag", {31'h0, flag}, {31'h0, exp});
    endtask : flag_is

    task automatic rx_words(input int n);
        for (int i = 0; i < n; i++) model_u.send(32'h0000_1100 + i, i % 2);
        repeat (10) @(posedge clk);
    endtask : rx_words

    // =====================================================================
    // scenarios
    task automatic sc_tx(input logic [7:0] ctrl, input logic [31:0] w);
        logic [31:0] exp;
        int n0;
        n0 = nbits;
        exp = {~^w[30:0], w[30:8], ctrl[2] ? rev8(w[7:0]) : w[7:0]};
        wr1(OP_WR_CTRL, ctrl);
        put(1'b1, OP_WR_TX);
        for (int i = 3; i >= 0; i--) put(1'b0, w[8*i+:8]);
        for (int i = 0; i < 400 && nbits < n0 + 32; i++) @(posedge clk);
        // linger so that a stray 33rd bit would show in the count
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("tx word", cap, exp);
        chk("tx bit count", nbits - n0, 32);
    endtask : sc_tx

    task automatic sc_rx();
        logic [31:0] w, r;
        // top bit already equals the odd parity that the line will carry
        w = 32'ha345_67c1;
        wr1(OP_WR_MATCH, 8'hc1);
        wr1(OP_WR_CTRL, 8'h08);
        model_u.send(w, 2);
        repeat (10) @(posedge clk);
        flag_is(1'b0);
        rd_word(OP_RD_PRIO, BYTES_PRIO, r);
        chk("priority word", r, {8'h00, w[31:8]});
        rd_word(OP_RD_RX1, BYTES_WORD, r);
        chk("rx word", r, {~^w[30:0], w[30:8], rev8(w[7:0])});
        flag_is(1'b1);
    endtask : sc_rx

    task automatic sc_flag();
        wr1(OP_WR_CTRL, {6'h0, FLAG_ANY});
        flag_is(1'b0);
        rx_words(1);
        flag_is(1'b1);
        wr1(OP_WR_CTRL, {6'h0, FLAG_HALF});
        flag_is(1'b0);
        rx_words(15);
        flag_is(1'b1);
        wr1(OP_WR_CTRL, {6'h0, FLAG_FULL});
        flag_is(1'b0);
        rx_words(16);
        flag_is(1'b1);
        wr1(OP_WR_CTRL, {6'h0, FLAG_EMPTY});
        flag_is(1'b0);
    endtask : sc_flag

    // =====================================================================
    // closing report
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        resetn = 1'b0;
        lresetn = 1'b0;
        hv = 1'b0;
        hs = 1'b0;
        hb = 8'h00;
        cap = '0;
        nbits = 0;
        failures = 0;
        checks_done = 0;
        cyc = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge lclk);
        lresetn <= 1'b1;
        // empty buffer and zero selector after reset
        flag_is(1'b1);
        sc_tx(8'h00, 32'h1234_56a5);
        sc_tx(8'h04, 32'h8765_4303);
        sc_rx();
        sc_flag();
        results();
    end
endmodule : tb_arinc_word_label_ordering

`default_nettype wire
